// >>> hw/option_cfg_pkg.sv
package option_cfg_pkg;

	// =========================================================
	// Register map
	localparam logic [11:0] addr_option_byte = 12'h000;
	localparam logic [11:0] addr_status = 12'h004;
	localparam logic [11:0] addr_wdog_ctrl = 12'h008;
	localparam logic [11:0] addr_flash_req = 12'h00c;
	localparam logic [11:0] addr_debug_ctrl = 12'h010;

	// =========================================================
	// Option byte field positions and erased value
	localparam int pos_wdog_reset_sel = 7;
	localparam int pos_wdog_always_on = 6;
	localparam int pos_osc_hi = 5;
	localparam int pos_osc_lo = 4;
	localparam int pos_brownout_ao = 3;
	localparam int pos_read_protect = 2;
	localparam int pos_reserved = 1;
	localparam int pos_write_protect = 0;
	localparam logic [7:0] option_erased = 8'hff;

	// =========================================================
	// Oscillator drive modes
	localparam logic [1:0] osc_rc_network = 2'h0;
	localparam logic [1:0] osc_min_power = 2'h1;
	localparam logic [1:0] osc_med_power = 2'h2;
	localparam logic [1:0] osc_max_power = 2'h3;

	// =========================================================
	// Flash request encoding in the request register
	localparam logic [1:0] flash_op_none = 2'h0;
	localparam logic [1:0] flash_op_program = 2'h1;
	localparam logic [1:0] flash_op_page_erase = 2'h2;
	localparam logic [1:0] flash_op_mass_erase = 2'h3;

	// =========================================================
	// Bus responses
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;

endpackage : option_cfg_pkg

// >>> hw/cfg_fields_if.sv
`timescale 1ns/1ps
interface cfg_fields_if;
	logic [7:0] option_byte;
	logic wdog_timeout_reset_sel;
	logic wdog_always_on;
	logic [1:0] osc_drive_mode;
	logic brownout_always_on;
	logic code_read_protect;
	logic code_write_protect;

	modport producer(
		input option_byte,
		output wdog_timeout_reset_sel,
		output wdog_always_on,
		output osc_drive_mode,
		output brownout_always_on,
		output code_read_protect,
		output code_write_protect
	);
	modport consumer(
		output option_byte,
		input wdog_timeout_reset_sel,
		input wdog_always_on,
		input osc_drive_mode,
		input brownout_always_on,
		input code_read_protect,
		input code_write_protect
	);
endinterface : cfg_fields_if

// >>> hw/option_field_latch.sv
`timescale 1ns/1ps
module option_field_latch (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic load,
	cfg_fields_if.producer fields
);
	// =========================================================
	// Decoded fields, taken from the stored byte after reset
	logic [7:0] dec_q;
	logic [7:0] dec_d;

	always_comb begin
		dec_d = dec_q;
		if (load) begin
			dec_d = fields.option_byte;
		end
	end

	// Reset loads the erased pattern so an unloaded part runs with safe defaults.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			dec_q <= option_cfg_pkg::option_erased;
		end else begin
			dec_q <= dec_d;
		end
	end

	assign fields.wdog_timeout_reset_sel = dec_q[option_cfg_pkg::pos_wdog_reset_sel];
	assign fields.wdog_always_on = dec_q[option_cfg_pkg::pos_wdog_always_on];
	assign fields.osc_drive_mode = dec_q[option_cfg_pkg::pos_osc_hi:option_cfg_pkg::pos_osc_lo];
	assign fields.brownout_always_on = dec_q[option_cfg_pkg::pos_brownout_ao];
	assign fields.code_read_protect = dec_q[option_cfg_pkg::pos_read_protect];
	assign fields.code_write_protect = dec_q[option_cfg_pkg::pos_write_protect];
endmodule : option_field_latch

// >>> hw/option_byte_store.sv
`timescale 1ns/1ps
module option_byte_store (
	input wire logic clock,
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	output logic [7:0] rd_data
);
	// =========================================================
	// Nonvolatile image: no reset, so a system reset leaves it unchanged.
	logic [7:0] mem_q = option_cfg_pkg::option_erased;
	logic [7:0] mem_d;

	always_comb begin
		mem_d = mem_q;
		if (wr_en) begin
			// The reserved bit is forced to one whatever software writes.
			mem_d = wr_data | (8'h01 << option_cfg_pkg::pos_reserved);
		end
	end

	always_ff @(posedge clock) begin
		mem_q <= mem_d;
		rd_data <= mem_d;
	end
endmodule : option_byte_store

// >>> hw/option_byte_config_decoder.sv
`timescale 1ns/1ps
module option_byte_config_decoder (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic wdog_timeout,
	input wire logic irq_global_enable,
	input wire logic stop_mode,
	input wire logic stop_recovery,
	input wire logic brownout_pwr_off_bit,
	output logic wdog_running,
	output logic wdog_irq_ack,
	output logic wdog_irq_pending,
	output logic system_reset_req,
	output logic [1:0] osc_drive_mode,
	output logic brownout_enable,
	output logic user_code_access,
	output logic debug_full_access,
	output logic flash_op_grant,
	output logic flash_op_refused
);
	// =========================================================
	// Decoded configuration
	cfg_fields_if fields();
	logic [7:0] store_rd;
	logic store_wr;
	logic load_q;
	logic [31:0] wdata_q, wdata_d;

	option_byte_store u_store (
		.clock(clock),
		.wr_en(store_wr),
		.wr_data(wdata_q[7:0]),
		.rd_data(store_rd)
	);

	assign fields.option_byte = store_rd;

	option_field_latch u_latch (
		.clock(clock),
		.rst_b(rst_b),
		.load(load_q),
		.fields(fields)
	);

	// =========================================================
	// Bus slave state
	logic aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_q, bvalid_d;
	logic [11:0] awaddr_q, awaddr_d;
	logic [3:0] wstrb_q, wstrb_d;
	// Readies live in flops of their own so that every bus output leaves a register.
	logic awready_q, wready_q, arready_q;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic wdog_start_instruction_q, wdog_start_instruction_d;
	logic [1:0] flash_req_q, flash_req_d;
	logic flash_from_debug_q, flash_from_debug_d;
	logic load_d;
	logic do_write;

	// Status word packs the decoded fields with live control outputs.
	function automatic logic [31:0] status_word(input logic [7:0] f, input logic run,
		input logic pend, input logic bo);
		status_word = {21'h0, bo, pend, run, f};
	endfunction : status_word

	logic [7:0] fields_packed;
	assign fields_packed = {fields.wdog_timeout_reset_sel, fields.wdog_always_on,
		fields.osc_drive_mode, fields.brownout_always_on, fields.code_read_protect,
		1'b1, fields.code_write_protect};

	assign do_write = aw_have_q && w_have_q && !bvalid_q;
	assign store_wr = do_write && (awaddr_q == option_cfg_pkg::addr_option_byte) && wstrb_q[0];

	always_comb begin
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		wdog_start_instruction_d = 1'b0;
		flash_req_d = option_cfg_pkg::flash_op_none;
		flash_from_debug_d = 1'b0;
		load_d = 1'b0;
		if (s_axi_awvalid && !aw_have_q) begin
			aw_have_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_have_q) begin
			w_have_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		if (do_write) begin
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = option_cfg_pkg::resp_okay;
			case (awaddr_q)
				option_cfg_pkg::addr_option_byte: begin
				end
				option_cfg_pkg::addr_wdog_ctrl: begin
					wdog_start_instruction_d = wstrb_q[0] & wdata_q[0];
				end
				option_cfg_pkg::addr_flash_req: begin
					flash_req_d = wstrb_q[0] ? wdata_q[1:0] : option_cfg_pkg::flash_op_none;
					flash_from_debug_d = wdata_q[4];
				end
				option_cfg_pkg::addr_debug_ctrl: begin
					// Reloading the fields mimics the reset-time fetch without a reset.
					load_d = wstrb_q[0] & wdata_q[0];
				end
				default: begin
					bresp_d = option_cfg_pkg::resp_slverr;
				end
			endcase
		end
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (s_axi_arvalid && !rvalid_q) begin
			rvalid_d = 1'b1;
			rresp_d = option_cfg_pkg::resp_okay;
			case (s_axi_araddr)
				option_cfg_pkg::addr_option_byte: begin
					rdata_d = {24'h000000, store_rd};
				end
				option_cfg_pkg::addr_status: begin
					rdata_d = status_word(fields_packed, wdog_running, wdog_irq_pending,
						brownout_enable);
				end
				default: begin
					rdata_d = 32'h00000000;
					rresp_d = option_cfg_pkg::resp_slverr;
				end
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end

	// Load pulses once on the first edge after reset release; store keeps its value.
	logic boot_q;
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= 12'h000;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= 2'h0;
			rvalid_q <= 1'b0;
			rresp_q <= 2'h0;
			rdata_q <= 32'h00000000;
			wdog_start_instruction_q <= 1'b0;
			flash_req_q <= 2'h0;
			flash_from_debug_q <= 1'b0;
			boot_q <= 1'b1;
			load_q <= 1'b0;
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			arready_q <= 1'b1;
		end else begin
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			wdog_start_instruction_q <= wdog_start_instruction_d;
			flash_req_q <= flash_req_d;
			flash_from_debug_q <= flash_from_debug_d;
			boot_q <= 1'b0;
			load_q <= boot_q | load_d;
			awready_q <= !aw_have_d;
			wready_q <= !w_have_d;
			arready_q <= !rvalid_d;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;

	// =========================================================
	// Watchdog policy, oscillator, brownout, protection outputs
	logic run_q, run_d, pend_q, pend_d, ack_q, ack_d, sysrst_q, sysrst_d;
	logic [1:0] osc_q, osc_d;
	logic bo_q, bo_d, uca_q, uca_d, dbg_q, dbg_d, grant_q, grant_d, refuse_q, refuse_d;
	logic booted_q;

	always_comb begin
		run_d = run_q;
		pend_d = pend_q;
		ack_d = 1'b0;
		sysrst_d = 1'b0;
		if (!fields.wdog_always_on) begin
			run_d = booted_q;
		end else if (stop_recovery) begin
			run_d = 1'b0;
		end else if (wdog_start_instruction_q) begin
			run_d = 1'b1;
		end
		if (wdog_timeout && run_q) begin
			if (fields.wdog_timeout_reset_sel) begin
				sysrst_d = 1'b1;
			end else begin
				pend_d = 1'b1;
			end
		end
		if (pend_q && irq_global_enable) begin
			ack_d = 1'b1;
			pend_d = wdog_timeout && run_q && !fields.wdog_timeout_reset_sel;
		end
		osc_d = fields.osc_drive_mode;
		bo_d = fields.brownout_always_on || !stop_mode || !brownout_pwr_off_bit;
		uca_d = fields.code_read_protect;
		dbg_d = fields.code_read_protect;
		grant_d = 1'b0;
		refuse_d = 1'b0;
		if (flash_req_q != option_cfg_pkg::flash_op_none) begin
			if (fields.code_write_protect) begin
				grant_d = 1'b1;
			end else if (flash_from_debug_q &&
				flash_req_q == option_cfg_pkg::flash_op_mass_erase) begin
				grant_d = 1'b1;
			end else begin
				refuse_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			run_q <= 1'b0;
			pend_q <= 1'b0;
			ack_q <= 1'b0;
			sysrst_q <= 1'b0;
			osc_q <= option_cfg_pkg::osc_max_power;
			bo_q <= 1'b1;
			uca_q <= 1'b1;
			dbg_q <= 1'b1;
			grant_q <= 1'b0;
			refuse_q <= 1'b0;
			booted_q <= 1'b0;
		end else begin
			run_q <= run_d;
			pend_q <= pend_d;
			ack_q <= ack_d;
			sysrst_q <= sysrst_d;
			osc_q <= osc_d;
			bo_q <= bo_d;
			uca_q <= uca_d;
			dbg_q <= dbg_d;
			grant_q <= grant_d;
			refuse_q <= refuse_d;
			booted_q <= booted_q | load_q;
		end
	end

	assign wdog_running = run_q;
	assign wdog_irq_pending = pend_q;
	assign wdog_irq_ack = ack_q;
	assign system_reset_req = sysrst_q;
	assign osc_drive_mode = osc_q;
	assign brownout_enable = bo_q;
	assign user_code_access = uca_q;
	assign debug_full_access = dbg_q;
	assign flash_op_grant = grant_q;
	assign flash_op_refused = refuse_q;
endmodule : option_byte_config_decoder

// >>> testbench/option_cfg_chk.sv
`timescale 1ns/1ps
module option_cfg_chk (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic wdog_timeout,
	input wire logic irq_global_enable,
	input wire logic stop_mode,
	input wire logic stop_recovery,
	input wire logic brownout_pwr_off_bit,
	input wire logic wdog_running,
	input wire logic wdog_irq_ack,
	input wire logic wdog_irq_pending,
	input wire logic system_reset_req,
	input wire logic brownout_enable,
	input wire logic user_code_access,
	input wire logic debug_full_access,
	input wire logic flash_op_grant,
	input wire logic flash_op_refused
);
	// ========================================
	// Watchdog steps
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	sequence s_hit;
		wdog_timeout && wdog_running;
	endsequence
	sequence s_due;
		wdog_irq_pending && irq_global_enable;
	endsequence
	AST_TIMEOUT_ACTS: assert property (
		s_hit |=> system_reset_req || wdog_irq_pending)
		else $error("time-out left no reset and no request");
	AST_RESET_CAUSE: assert property (
		system_reset_req |-> $past(wdog_timeout && wdog_running))
		else $error("system reset without a running time-out");
	AST_ACK_CAUSE: assert property (
		wdog_irq_ack |-> $past(wdog_irq_pending && irq_global_enable))
		else $error("ack without pending request and enable");
	AST_ACK_DUE: assert property (s_due |=> wdog_irq_ack)
		else $error("enabled pending request not acknowledged");
	AST_ACK_CLEARS: assert property (
		wdog_irq_ack && !$past(wdog_timeout) |-> !wdog_irq_pending)
		else $error("request still pending after ack");
	AST_RUN_HOLDS: assert property (
		wdog_running && !stop_recovery |=> wdog_running)
		else $error("watchdog stopped without reset or recovery");
	// ========================================
	// Brownout, flash and access
	AST_BO_OFF_CAUSE: assert property (
		$fell(brownout_enable) |-> $past(stop_mode && brownout_pwr_off_bit))
		else $error("brownout dropped outside stop with power bit");
	AST_BO_OUTSIDE_STOP: assert property (
		!stop_mode |=> brownout_enable)
		else $error("brownout dropped outside stop mode");
	AST_FLASH_PULSE: assert property (
		flash_op_grant || flash_op_refused |-> !(flash_op_grant && flash_op_refused)
		##1 !(flash_op_grant || flash_op_refused))
		else $error("flash answer not a single exclusive pulse");
	AST_ACCESS_PAIR: assert property (
		user_code_access == debug_full_access)
		else $error("code access and debug access disagree");
endmodule : option_cfg_chk

bind option_byte_config_decoder option_cfg_chk chk_i (.*);

// >>> testbench/tb_option_byte_config_decoder.sv
`timescale 1ns/1ps
module tb_option_byte_config_decoder;
	// ========================================
	// Signals
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, wdog_timeout = 1'b0;
	logic irq_global_enable = 1'b0, stop_mode = 1'b0, stop_recovery = 1'b0;
	logic brownout_pwr_off_bit = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic wdog_running, wdog_irq_ack, wdog_irq_pending, system_reset_req, brownout_enable;
	logic user_code_access, debug_full_access, flash_op_grant, flash_op_refused;
	logic [31:0] s_axi_rdata, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp, osc_drive_mode, rs, bs;
	int fails, cmp_count, grants, refusals, resets, acks;

	option_byte_config_decoder DUT (.*);

	always #2 clock = ~clock;

	// Pulses are counted here so a check never depends on hitting the exact cycle.
	always @(posedge clock) begin
		if (flash_op_grant) grants <= grants + 1;
		if (flash_op_refused) refusals <= refusals + 1;
		if (system_reset_req) resets <= resets + 1;
		if (wdog_irq_ack) acks <= acks + 1;
	end

	// ========================================
	// Common tasks
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic hang;
		fails++;
		$display("[FAIL] bus answer expected 1 seen 0");
		tally_and_finish();
	endtask : hang

	task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				bs = s_axi_bresp;
				break;
			end
		end
		s_axi_bready <= 1'b0;
		if (n == 50) hang();
		@(posedge clock);
	endtask : axi_write

	task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n == 50) hang();
		@(posedge clock);
	endtask : axi_read

	task automatic do_reset;
		rst_b <= 1'b0;
		repeat (3) @(posedge clock);
		rst_b <= 1'b1;
		repeat (4) @(posedge clock);
	endtask : do_reset

	// The stored byte only reaches the fields through a reload or a reset.
	task automatic load_byte(input logic [7:0] b);
		axi_write(option_cfg_pkg::addr_option_byte, {24'h0, b});
		axi_write(option_cfg_pkg::addr_debug_ctrl, 32'h1);
		repeat (4) @(posedge clock);
	endtask : load_byte

	task automatic pulse(input bit rec);
		if (rec) stop_recovery <= 1'b1;
		else wdog_timeout <= 1'b1;
		@(posedge clock);
		stop_recovery <= 1'b0;
		wdog_timeout <= 1'b0;
		repeat (3) @(posedge clock);
	endtask : pulse

	task automatic flash_try(input logic [4:0] req, input logic g);
		int b0;
		b0 = grants + 2 * refusals;
		axi_write(option_cfg_pkg::addr_flash_req, {27'h0, req});
		repeat (4) @(posedge clock);
		chk("flash answer", g ? 1 : 2, grants + 2 * refusals - b0);
	endtask : flash_try

	// ========================================
	// Scenarios
	task automatic t_erased;
		axi_read(option_cfg_pkg::addr_option_byte, rd, rs);
		chk("byte", 32'hff, rd);
		chk("read resp", option_cfg_pkg::resp_okay, rs);
		chk("osc", 3, osc_drive_mode);
		chk("brownout", 1, brownout_enable);
		chk("code access", 1, user_code_access);
		chk("debug access", 1, debug_full_access);
		chk("running", 0, wdog_running);
		s_axi_wstrb <= 4'h0;
		axi_write(option_cfg_pkg::addr_option_byte, 32'h0);
		s_axi_wstrb <= 4'h1;
		chk("masked wresp", option_cfg_pkg::resp_okay, bs);
		axi_read(option_cfg_pkg::addr_option_byte, rd, rs);
		chk("masked byte", 32'hff, rd);
		axi_write(12'h020, 32'h0);
		chk("unmapped wresp", option_cfg_pkg::resp_slverr, bs);
		axi_read(12'h020, rd, rs);
		chk("unmapped resp", option_cfg_pkg::resp_slverr, rs);
		chk("unmapped data", 0, rd);
		$display("test erased done");
	endtask : t_erased

	task automatic t_wdog;
		int r0;
		axi_write(option_cfg_pkg::addr_wdog_ctrl, 32'h1);
		chk("wresp", option_cfg_pkg::resp_okay, bs);
		chk("running", 1, wdog_running);
		r0 = resets;
		pulse(1'b0);
		chk("reset req", r0 + 1, resets);
		chk("pending", 0, wdog_irq_pending);
		do_reset();
		chk("running", 0, wdog_running);
		$display("test watchdog reset done");
	endtask : t_wdog

	task automatic t_fields;
		load_byte(8'h00);
		axi_read(option_cfg_pkg::addr_option_byte, rd, rs);
		chk("byte", 32'h02, rd);
		chk("code access", 0, user_code_access);
		chk("debug access", 0, debug_full_access);
		do_reset();
		chk("running", 1, wdog_running);
		pulse(1'b1);
		chk("running", 1, wdog_running);
		for (int i = 0; i < 4; i++) begin
			load_byte({2'h3, 2'(i), 4'hf});
			chk("osc", i, osc_drive_mode);
		end
		axi_write(option_cfg_pkg::addr_option_byte, 32'h5a);
		repeat (4) @(posedge clock);
		chk("osc held", 3, osc_drive_mode);
		do_reset();
		chk("osc after reset", 1, osc_drive_mode);
		$display("test fields done");
	endtask : t_fields

	task automatic t_irq;
		int a0;
		int r0;
		load_byte(8'h7f);
		axi_write(option_cfg_pkg::addr_wdog_ctrl, 32'h1);
		a0 = acks;
		r0 = resets;
		pulse(1'b0);
		chk("pending", 1, wdog_irq_pending);
		axi_read(option_cfg_pkg::addr_status, rd, rs);
		chk("status", 32'h0000077f, rd);
		chk("reset req", r0, resets);
		chk("ack", a0, acks);
		irq_global_enable <= 1'b1;
		repeat (3) @(posedge clock);
		chk("ack", a0 + 1, acks);
		chk("pending", 0, wdog_irq_pending);
		irq_global_enable <= 1'b0;
		pulse(1'b1);
		chk("running", 0, wdog_running);
		$display("test watchdog request done");
	endtask : t_irq

	task automatic t_flash;
		load_byte(8'hfe);
		for (int i = 1; i < 4; i++) flash_try(5'(i), 1'b0);
		flash_try(5'h13, 1'b1);
		flash_try(5'h11, 1'b0);
		load_byte(8'hff);
		for (int i = 1; i < 4; i++) flash_try(5'(i), 1'b1);
		$display("test flash done");
	endtask : t_flash

	task automatic t_brownout;
		load_byte(8'hf7);
		stop_mode <= 1'b1;
		repeat (3) @(posedge clock);
		chk("brownout", 1, brownout_enable);
		brownout_pwr_off_bit <= 1'b1;
		repeat (3) @(posedge clock);
		chk("brownout", 0, brownout_enable);
		load_byte(8'hff);
		chk("brownout", 1, brownout_enable);
		stop_mode <= 1'b0;
		brownout_pwr_off_bit <= 1'b0;
		$display("test brownout done");
	endtask : t_brownout

	// ========================================
	// Main sequence
	initial begin
		#200000;
		hang();
	end

	initial begin
		do_reset();
		t_erased();
		t_wdog();
		t_fields();
		t_irq();
		t_flash();
		t_brownout();
		tally_and_finish();
	end
endmodule : tb_option_byte_config_decoder
